/* common/pms_pkg.sv */
// Purpose: constants and carrier types for the power mode / options block
// Assumes: one 10 MHz system clock, synchronous active-high reset
// Notes:   register index 0x11 sits at byte address 0x44 on the bus
package pms_pkg;

  // register map: printed offsets are not multiples of four, so indices
  localparam logic [7:0] PMS_IDX_OPTIONS  = 8'h11; // system options
  localparam logic [7:0] PMS_IDX_MODE     = 8'h12; // mode control/status
  localparam logic [7:0] PMS_IDX_PERIPH   = 8'h13; // peripheral flag image
  localparam int         PMS_ADDR_W       = 10;    // byte address width

  // system options field positions
  localparam int PMS_OPT_LVFLAG  = 7;
  localparam int PMS_OPT_LOW_VOLT_INT_ENABLE    = 6;
  localparam int PMS_OPT_LVPWR   = 5;
  localparam int PMS_OPT_SLOW    = 4;
  localparam int PMS_OPT_IRQSENS = 3;
  localparam logic [7:0] PMS_OPT_RESET = 8'h00;
  localparam logic [7:0] PMS_OPT_WMASK = 8'h78; // bits 2..0 read zero

  // mode register: write bit0 = stop request, bit1 = wait request
  localparam int PMS_MODE_STOP = 0;
  localparam int PMS_MODE_WAIT = 1;

  // peripheral flag image bits cleared on stop entry
  localparam logic [7:0] PMS_PERIPH_RESET = 8'h00;

  // unmapped read answer
  localparam logic [31:0] PMS_BAD_READ = 32'h0000_0000;

  // clock figures
  localparam int PMS_CLK_HZ = 10_000_000;

  // power state; stop -> wake -> run steps one bit, run -> stop and wait -> wake two
  typedef enum logic [1:0] {
    PMS_RUN  = 2'b00,
    PMS_WAIT = 2'b01,
    PMS_STOP = 2'b11,
    PMS_WAKE = 2'b10
  } pms_state_t;

  // wake sources bundled together
  typedef struct packed {
    logic irq;      // external interrupt pending
    logic key;      // keyboard interrupt pending
    logic low_volt_detector;      // low-voltage interrupt pending
    logic ctimer;   // core timer interrupt pending
    logic timer16;  // 16-bit timer interrupt pending
  } pms_wake_t;

endpackage

/* rtl/pms_top.sv */
// Purpose: stop/wait mode sequencing, system options register, reset pin
// Assumes: inputs synchronous to sys_clk_i, Avalon-MM slave with waitrequest
// Notes:   the block drives enables and clear strobes to the core and timers
`timescale 1ns/10ps
module pms_top
  import pms_pkg::*;
#(
  parameter bit STOP_ENABLED = 1'b1,  // fabrication option: stop allowed
  parameter bit LVR_ENABLED  = 1'b1,  // fabrication option: low-volt reset
  parameter int PORT_W       = 32     // general-purpose port lines
)
(
  input  wire logic                          sys_clk_i,
  input  wire logic                          srst_i,
  // avalon-mm slave
  input  wire logic [pms_pkg::PMS_ADDR_W-1:0] avs_address_i,
  input  wire logic                          avs_read_i,
  input  wire logic                          avs_write_i,
  input  wire logic [31:0]                   avs_writedata_i,
  input  wire logic [3:0]                    avs_byteenable_i,
  output logic [31:0]                        avs_readdata_o,
  output logic                               avs_waitrequest_o,
  // core handshake
  input  wire logic                          stop_instr_i,
  input  wire logic                          wait_instr_i,
  input  wire logic                          cpu_imask_i,
  input  wire pms_pkg::pms_wake_t            wake_src_i,
  // pins and analog
  input  wire logic                          irq_pin_i,
  input  wire logic                          reset_pin_i,
  input  wire logic                          lv_below_i,
  input  wire logic                          lv_reset_i,
  input  wire logic                          wdog_reset_i,
  // outputs
  output logic                               osc_run_o,
  output logic                               cpu_halt_o,
  output logic                               timers_run_o,
  output logic                               imask_clear_o,
  output logic                               timer_flags_clear_o,
  output logic                               cpu_int_req_o,
  output logic                               irq_event_o,
  output logic                               bus_clk_en_o,
  output logic                               tone_clk_en_o,
  output logic                               reset_pin_o,
  output logic                               reset_pin_oe_o,
  output logic                               chip_reset_o,
  output logic [PORT_W-1:0]                  port_dir_force_in_o,
  output logic                               lv_detector_power_o
);

  // avalon byte address -> register index (word address)
  function automatic logic [7:0] reg_index(
    input logic [pms_pkg::PMS_ADDR_W-1:0] a);
    reg_index = a[9:2];
  endfunction

  // combined reset: sync reset, external pin, low-volt reset
  logic any_reset;            // full device reset
  assign any_reset = srst_i | ~reset_pin_i | (LVR_ENABLED & lv_reset_i);

  logic [7:0]  options_ff;    // system options register
  logic [7:0]  periph_ff;     // image of cleared wake source flags
  pms_state_t  state_ff;      // power state
  pms_state_t  nxt_state;     // next power state
  logic        rd_ack_ff;     // answer pending for read/write
  logic [31:0] rdata_ff;      // read data
  logic        div_ff;        // osc/2 toggle
  logic [1:0]  div4_ff;       // osc/4 counter
  logic        slow_sel_ff;   // bus divide select, taken on a boundary
  logic        irq_prev_ff;   // previous irq pin level
  logic        intreq_ff;     // interrupt request output
  logic        irqev_ff;      // irq event output
  logic        lvflag_set;    // low-volt flag set condition

  // bus decode
  logic        acc;           // access this cycle not yet answered
  logic        wr_opt;        // write to options, low byte enabled
  logic        wr_mode;       // write to mode register
  assign acc     = (avs_read_i | avs_write_i) & ~rd_ack_ff;
  // writes land on the edge where the master sees waitrequest low
  assign wr_opt  = rd_ack_ff & avs_write_i & avs_byteenable_i[0]
                 & (reg_index(avs_address_i) == PMS_IDX_OPTIONS);
  assign wr_mode = rd_ack_ff & avs_write_i & avs_byteenable_i[0]
                 & (reg_index(avs_address_i) == PMS_IDX_MODE);

  // flag set only when option, detector power and enable all present
  assign lvflag_set = LVR_ENABLED & lv_below_i
                    & options_ff[PMS_OPT_LVPWR]
                    & options_ff[PMS_OPT_LOW_VOLT_INT_ENABLE];

  // options register: writable bits, read-only flag with set priority
  always_ff @(posedge sys_clk_i)
  begin
    if (any_reset)
    begin
      options_ff <= PMS_OPT_RESET;
    end
    else
    begin
      if (wr_opt)
      begin
        // flag bit is not writable; low bits stay zero
        options_ff[6:3] <= avs_writedata_i[6:3];
      end
      // set wins over the clear made by dropping the enable
      if (lvflag_set)
        options_ff[PMS_OPT_LVFLAG] <= 1'b1;
      else if (wr_opt && !avs_writedata_i[PMS_OPT_LOW_VOLT_INT_ENABLE])
        options_ff[PMS_OPT_LVFLAG] <= 1'b0;
      else if (!options_ff[PMS_OPT_LOW_VOLT_INT_ENABLE])
        options_ff[PMS_OPT_LVFLAG] <= 1'b0;
    end
  end

  // software must power the detector first; the flag just stays clear
  // until both bits are present, so an early enable does no harm

  // power state machine
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      PMS_RUN:
      begin
        if ((stop_instr_i | (wr_mode & avs_writedata_i[PMS_MODE_STOP]))
            && STOP_ENABLED)
          nxt_state = PMS_STOP;
        else if (wait_instr_i | (wr_mode & avs_writedata_i[PMS_MODE_WAIT]))
          nxt_state = PMS_WAIT;
      end
      PMS_STOP:
      begin
        if (wake_src_i.irq | wake_src_i.key | wake_src_i.low_volt_detector | irqev_ff)
          nxt_state = PMS_WAKE;
      end
      PMS_WAIT:
      begin
        if (wake_src_i.irq | wake_src_i.key | wake_src_i.low_volt_detector
            | wake_src_i.ctimer | wake_src_i.timer16 | irqev_ff
            | intreq_ff)
          nxt_state = PMS_WAKE;
      end
      PMS_WAKE:
        nxt_state = PMS_RUN;
      default:
        nxt_state = PMS_RUN;
    endcase
  end

  // state register; any reset returns to run
  always_ff @(posedge sys_clk_i)
  begin
    if (any_reset)
      state_ff <= PMS_RUN;
    else
      state_ff <= nxt_state;
  end

  // mode outputs
  always_ff @(posedge sys_clk_i)
  begin
    if (any_reset)
    begin
      osc_run_o           <= 1'b1;
      cpu_halt_o          <= 1'b0;
      timers_run_o        <= 1'b1;
      imask_clear_o       <= 1'b0;
      timer_flags_clear_o <= 1'b0;
    end
    else
    begin
      // oscillator and timers off only in stop
      osc_run_o    <= (nxt_state != PMS_STOP);
      timers_run_o <= (nxt_state != PMS_STOP);
      cpu_halt_o   <= (nxt_state == PMS_STOP)
                    | (nxt_state == PMS_WAIT);
      // one-cycle strobes on entry; periph_ff is also cleared on stop entry
      imask_clear_o <= (state_ff == PMS_RUN)
                     & ((nxt_state == PMS_STOP)
                     | (nxt_state == PMS_WAIT));
      timer_flags_clear_o <= (state_ff == PMS_RUN)
                           & (nxt_state == PMS_STOP);
    end
  end

  // image of cleared flags for software visibility
  always_ff @(posedge sys_clk_i)
  begin
    if (any_reset)
      periph_ff <= PMS_PERIPH_RESET;
    else if ((state_ff == PMS_RUN) && (nxt_state == PMS_STOP))
      periph_ff <= PMS_PERIPH_RESET;
    else
      periph_ff <= {3'h0, wake_src_i};
  end

  // clock dividers: osc/2 tone, osc/2 or osc/4 bus
  always_ff @(posedge sys_clk_i)
  begin
    if (any_reset)
    begin
      div_ff        <= 1'b0;
      div4_ff       <= 2'h0;
      slow_sel_ff   <= 1'b0;
      bus_clk_en_o  <= 1'b0;
      tone_clk_en_o <= 1'b0;
    end
    else if (nxt_state == PMS_STOP)
    begin
      // oscillator off: no enables from the entry edge on
      bus_clk_en_o  <= 1'b0;
      tone_clk_en_o <= 1'b0;
    end
    else
    begin
      div_ff        <= ~div_ff;
      div4_ff       <= div4_ff + 2'h1;
      tone_clk_en_o <= div_ff;
      // select changes only where both rates pulse, so no short period
      if (div4_ff == 2'h3)
        slow_sel_ff <= options_ff[PMS_OPT_SLOW];
      bus_clk_en_o  <= slow_sel_ff ? (div4_ff == 2'h3)
                                   : div_ff;
    end
  end

  // external interrupt sensitivity
  always_ff @(posedge sys_clk_i)
  begin
    if (any_reset)
    begin
      irq_prev_ff <= 1'b1;
      irqev_ff    <= 1'b0;
    end
    else
    begin
      irq_prev_ff <= irq_pin_i;
      // falling edge always; low level too when sensitivity bit set
      irqev_ff <= (irq_prev_ff & ~irq_pin_i)
                | (options_ff[PMS_OPT_IRQSENS] & ~irq_pin_i);
    end
  end
  assign irq_event_o = irqev_ff;

  // low-volt cpu interrupt request
  always_ff @(posedge sys_clk_i)
  begin
    if (any_reset)
      intreq_ff <= 1'b0;
    else
      intreq_ff <= options_ff[PMS_OPT_LOW_VOLT_INT_ENABLE] & options_ff[PMS_OPT_LVFLAG]
                 & ~cpu_imask_i;
  end
  assign cpu_int_req_o = intreq_ff;

  // reset pin: only low-volt reset drives it, open drain low
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      reset_pin_oe_o <= 1'b0;
      reset_pin_o    <= 1'b0;
      chip_reset_o   <= 1'b1;
    end
    else
    begin
      reset_pin_o    <= 1'b0;
      reset_pin_oe_o <= LVR_ENABLED & lv_reset_i;
      chip_reset_o   <= any_reset | wdog_reset_i;
    end
  end

  // ports forced to input while any reset is active
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      port_dir_force_in_o <= '1;
    else
      port_dir_force_in_o <= {PORT_W{any_reset | wdog_reset_i}};
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
      lv_detector_power_o <= 1'b0;
    else
      lv_detector_power_o <= options_ff[PMS_OPT_LVPWR];
  end

  // avalon answer: one wait cycle, then ack
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      rd_ack_ff         <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      rdata_ff          <= PMS_BAD_READ;
    end
    else
    begin
      rd_ack_ff         <= acc;
      avs_waitrequest_o <= ~acc; // low exactly in the ack cycle
      if (acc && avs_read_i)
      begin
        case (reg_index(avs_address_i))
          PMS_IDX_OPTIONS: rdata_ff <= {24'h0, options_ff};
          PMS_IDX_MODE:    rdata_ff <= {30'h0, state_ff};
          PMS_IDX_PERIPH:  rdata_ff <= {24'h0, periph_ff};
          default:         rdata_ff <= PMS_BAD_READ;
        endcase
      end
    end
  end
  assign avs_readdata_o    = rdata_ff;

  // checks
  AST_LVFLAG_NEEDS_ARM: assert property (@(posedge sys_clk_i)
    disable iff (any_reset)
    $rose(options_ff[PMS_OPT_LVFLAG]) |-> $past(lvflag_set))
    else $error("low-volt flag set without arming");
  AST_LVFLAG_CLEAR: assert property (@(posedge sys_clk_i)
    disable iff (any_reset)
    (!options_ff[PMS_OPT_LOW_VOLT_INT_ENABLE] && !lvflag_set) |=>
      !options_ff[PMS_OPT_LVFLAG])
    else $error("low-volt flag not cleared");
  AST_INTREQ: assert property (@(posedge sys_clk_i)
    disable iff (any_reset)
    (options_ff[7] && options_ff[6] && !cpu_imask_i) |=> intreq_ff)
    else $error("missing low-volt interrupt request");
  AST_STOP_OPTION: assert property (@(posedge sys_clk_i)
    disable iff (any_reset)
    !STOP_ENABLED |-> state_ff != PMS_STOP)
    else $error("stop entered while disabled");
  AST_STOP_CLEARS: assert property (@(posedge sys_clk_i)
    disable iff (any_reset)
    (state_ff == PMS_RUN && nxt_state == PMS_STOP) |=>
      timer_flags_clear_o && imask_clear_o ##1 !timer_flags_clear_o)
    else $error("stop entry strobes wrong");
  AST_STOP_OSC: assert property (@(posedge sys_clk_i)
    disable iff (any_reset)
    (state_ff == PMS_STOP) |-> !osc_run_o && !bus_clk_en_o)
    else $error("oscillator running in stop");
  AST_WAIT_TIMERS: assert property (@(posedge sys_clk_i)
    disable iff (any_reset)
    (state_ff == PMS_WAIT) |-> timers_run_o && cpu_halt_o)
    else $error("wait mode outputs wrong");
  AST_IRQ_EDGE: assert property (@(posedge sys_clk_i)
    disable iff (any_reset)
    (irq_pin_i ##1 !irq_pin_i) |=> irqev_ff)
    else $error("falling edge of irq missed");
  AST_RESET_PIN: assert property (@(posedge sys_clk_i)
    disable iff (srst_i)
    (wdog_reset_i && !lv_reset_i) |=> !reset_pin_oe_o)
    else $error("reset pin driven by other source");
  AST_SLOW_CLK: assert property (@(posedge sys_clk_i)
    disable iff (any_reset)
    (bus_clk_en_o && options_ff[4] && $stable(options_ff[4])
     && state_ff == PMS_RUN) |=> !bus_clk_en_o [*3])
    else $error("slow bus clock too fast");
  COV_STOP:  cover property (@(posedge sys_clk_i) state_ff == PMS_STOP);
  COV_WAIT:  cover property (@(posedge sys_clk_i) state_ff == PMS_WAIT);
  COV_LVINT: cover property (@(posedge sys_clk_i) $rose(intreq_ff));

endmodule

/* testbench/pms_top_tb.sv */
// Purpose: self-checking bench for the power mode / options block
// Assumes: 10 MHz clock, sync reset, avalon-mm master with waitrequest
// Notes:   reset pin level is worked out here from the open-drain enable
`timescale 1ns/10ps
module pms_top_tb;
  import pms_pkg::*;

  logic              sys_clk_i        = 1'b0;
  logic              srst_i           = 1'b1;
  logic [9:0]        avs_address_i    = '0;
  logic              avs_read_i       = 1'b0;
  logic              avs_write_i      = 1'b0;
  logic [31:0]       avs_writedata_i  = '0;
  logic [3:0]        avs_byteenable_i = 4'h1; // byte lane 0 only
  logic              stop_instr_i     = 1'b0;
  logic              wait_instr_i     = 1'b0;
  logic              cpu_imask_i      = 1'b0;
  pms_wake_t         wake_src_i       = '0;
  logic              irq_pin_i        = 1'b1; // active low, idle high
  logic              ext_rst_n        = 1'b1; // outside reset source
  logic              lv_below_i       = 1'b0;
  logic              lv_reset_i       = 1'b0;
  logic              wdog_reset_i     = 1'b0;
  logic [31:0]       avs_readdata_o;
  logic              avs_waitrequest_o;
  logic              osc_run_o, cpu_halt_o, timers_run_o, imask_clear_o;
  logic              timer_flags_clear_o, cpu_int_req_o, irq_event_o;
  logic              bus_clk_en_o, tone_clk_en_o, reset_pin_o;
  logic              reset_pin_oe_o, chip_reset_o, lv_detector_power_o;
  logic [31:0]       port_dir_force_in_o;
  int                n_errors         = 0;
  int                tests_run        = 0;
  // pin is low when the outside holds it or our driver pulls it
  wire               reset_pin_i = ext_rst_n && (reset_pin_oe_o !== 1'b1);

  // 10 MHz clock
  always #50 sys_clk_i = ~sys_clk_i;

  pms_top pms_top_inst (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .stop_instr_i(stop_instr_i),
    .wait_instr_i(wait_instr_i), .cpu_imask_i(cpu_imask_i),
    .wake_src_i(wake_src_i), .irq_pin_i(irq_pin_i),
    .reset_pin_i(reset_pin_i), .lv_below_i(lv_below_i),
    .lv_reset_i(lv_reset_i), .wdog_reset_i(wdog_reset_i),
    .osc_run_o(osc_run_o), .cpu_halt_o(cpu_halt_o),
    .timers_run_o(timers_run_o), .imask_clear_o(imask_clear_o),
    .timer_flags_clear_o(timer_flags_clear_o),
    .cpu_int_req_o(cpu_int_req_o), .irq_event_o(irq_event_o),
    .bus_clk_en_o(bus_clk_en_o), .tone_clk_en_o(tone_clk_en_o),
    .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o),
    .chip_reset_o(chip_reset_o), .port_dir_force_in_o(port_dir_force_in_o),
    .lv_detector_power_o(lv_detector_power_o)
  );

  // verdict and end of run, shared with the watchdog
  task test_done();
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one comparison; four-state so an unknown never matches
  task chk(input string what, input logic [31:0] seen,
           input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one avalon access; request held until waitrequest is sampled low
  // at a rising edge, read data taken at that same edge
  task bus(input logic rd, input logic [7:0] idx, input logic [31:0] wd,
           output logic [31:0] rdat);
    @(posedge sys_clk_i);
    avs_address_i   <= {idx, 2'b00};
    avs_read_i      <= rd;
    avs_write_i     <= !rd;
    avs_writedata_i <= wd;
    @(posedge sys_clk_i);
    // only the watchdog ends a wait that never answers
    while (avs_waitrequest_o !== 1'b0)
      @(posedge sys_clk_i);
    rdat = avs_readdata_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  // count high cycles of an enable or event over n cycles
  task cnt(input int sel, input int n, output logic [31:0] c);
    c = '0;
    repeat (n)
    begin
      @(negedge sys_clk_i);
      if ((sel == 0 ? bus_clk_en_o : sel == 1 ? tone_clk_en_o :
           irq_event_o) === 1'b1)
        c++;
    end
  endtask

  // did osc_run (sel 0) or cpu_halt (sel 1) show v within 12 cycles
  task seen12(input int sel, input logic v, output logic ok);
    ok = 1'b0;
    repeat (12)
    begin
      @(negedge sys_clk_i);
      if ((sel == 0 ? osc_run_o : cpu_halt_o) === v)
        ok = 1'b1;
    end
  endtask

  // one-cycle stop or wait pulse; collects clear strobes after it
  task enter(input logic stp, output logic [1:0] pl);
    pl = 2'b00;
    @(posedge sys_clk_i);
    stop_instr_i <= stp;
    wait_instr_i <= !stp;
    @(posedge sys_clk_i);
    stop_instr_i <= 1'b0;
    wait_instr_i <= 1'b0;
    repeat (6)
    begin
      @(negedge sys_clk_i);
      if (imask_clear_o === 1'b1) pl[0] = 1'b1;
      if (timer_flags_clear_o === 1'b1) pl[1] = 1'b1;
    end
  endtask

  // watchdog, far beyond the few hundred cycles of the run
  initial
  begin
    #3_000_000;
    n_errors++;
    test_done();
  end

  // scratch shared by the scenario tasks
  logic [31:0] r, c;
  logic [1:0]  pl;
  logic        ok;

  // reset held 16 cycles; state seen while it stands
  task t_reset();
    repeat (15) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk("ports in", port_dir_force_in_o, 32'hffff_ffff);
    chk("idle wait", {31'd0, avs_waitrequest_o}, 32'h1);
    @(posedge sys_clk_i);
    srst_i <= 1'b0;
  endtask

  // reset value, read-only and fixed-zero bits, unmapped index
  task t_regs();
    bus(1'b1, PMS_IDX_OPTIONS, 0, r); chk("opt rst", r, 32'h0);
    bus(1'b0, PMS_IDX_OPTIONS, 32'hff, r);
    bus(1'b1, PMS_IDX_OPTIONS, 0, r); chk("opt ff", r, 32'h78);
    chk("det pwr", {31'd0, lv_detector_power_o}, 32'h1);
    bus(1'b0, 8'h30, 32'h0, r);
    bus(1'b1, 8'h30, 0, r); chk("unmapped", r, 32'h0);
    bus(1'b1, PMS_IDX_OPTIONS, 0, r); chk("opt kept", r, 32'h78);
  endtask

  // slow bus clock, tone clock unaffected
  task t_clocks();
    cnt(0, 40, c); chk("bus slow", c, 32'd10);
    cnt(1, 40, c); chk("tone slow", c, 32'd20);
    bus(1'b0, PMS_IDX_OPTIONS, 32'h00, r);
    // the divide select switches on the next osc/4 boundary
    repeat (4) @(posedge sys_clk_i);
    cnt(0, 40, c); chk("bus norm", c, 32'd20);
  endtask

  // low-volt flag: power first, then enable
  task t_lowvolt();
    bus(1'b0, PMS_IDX_OPTIONS, 32'h20, r);
    bus(1'b0, PMS_IDX_OPTIONS, 32'h60, r);
    lv_below_i <= 1'b1;
    bus(1'b1, PMS_IDX_OPTIONS, 0, r); chk("lv set", r, 32'he0);
    chk("lv req", {31'd0, cpu_int_req_o}, 32'h1);
    @(posedge sys_clk_i) cpu_imask_i <= 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk("lv masked", {31'd0, cpu_int_req_o}, 32'h0);
    @(posedge sys_clk_i) cpu_imask_i <= 1'b0;
    bus(1'b0, PMS_IDX_OPTIONS, 32'h20, r);
    bus(1'b1, PMS_IDX_OPTIONS, 0, r); chk("lv clr", r, 32'h20);
    chk("lv noreq", {31'd0, cpu_int_req_o}, 32'h0);
    lv_below_i <= 1'b0;
    bus(1'b0, PMS_IDX_OPTIONS, 32'h60, r);
    bus(1'b1, PMS_IDX_OPTIONS, 0, r); chk("lv arm", r, 32'h60);
    lv_below_i <= 1'b1;
    bus(1'b1, PMS_IDX_OPTIONS, 0, r); chk("lv rearm", r, 32'he0);
    lv_below_i <= 1'b0;
  endtask

  // irq edge-only, then edge and level
  task t_irq();
    bus(1'b0, PMS_IDX_OPTIONS, 32'h00, r);
    @(posedge sys_clk_i) irq_pin_i <= 1'b0;
    cnt(2, 4, c); chk("edge hit", {31'd0, c != 0}, 32'h1);
    cnt(2, 8, c); chk("edge only", c, 32'd0);
    @(posedge sys_clk_i) irq_pin_i <= 1'b1;
    bus(1'b0, PMS_IDX_OPTIONS, 32'h08, r);
    @(posedge sys_clk_i) irq_pin_i <= 1'b0;
    cnt(2, 4, c);
    cnt(2, 8, c); chk("level", {31'd0, c != 0}, 32'h1);
    @(posedge sys_clk_i) irq_pin_i <= 1'b1;
  endtask

  // stop: clears, halt, only listed wakes
  task t_stop();
    bus(1'b0, PMS_IDX_OPTIONS, 32'h18, r);
    enter(1'b1, pl); chk("stop clr", {30'd0, pl}, 32'h3);
    chk("osc off", {29'd0, osc_run_o, timers_run_o, cpu_halt_o},
        32'h1);
    @(posedge sys_clk_i) wake_src_i.ctimer <= 1'b1;
    seen12(0, 1'b1, ok); chk("no ct wake", {31'd0, ok}, 32'h0);
    @(posedge sys_clk_i) wake_src_i.ctimer <= 1'b0;
    wake_src_i.key <= 1'b1;
    seen12(0, 1'b1, ok); chk("key wake", {31'd0, ok}, 32'h1);
    @(posedge sys_clk_i) wake_src_i.key <= 1'b0;
    seen12(1, 1'b0, ok); chk("resume", {31'd0, ok}, 32'h1);
    bus(1'b1, PMS_IDX_OPTIONS, 0, r); chk("kept", r, 32'h18);
  endtask

  // wait: halt cpu only, any enabled interrupt wakes
  task t_wait();
    enter(1'b0, pl); chk("wait clr", {30'd0, pl}, 32'h1);
    chk("wait lv", {29'd0, osc_run_o, timers_run_o, cpu_halt_o},
        32'h7);
    cnt(1, 40, c); chk("tone wait", c, 32'd20);
    @(posedge sys_clk_i) wake_src_i.ctimer <= 1'b1;
    seen12(1, 1'b0, ok); chk("ct wake", {31'd0, ok}, 32'h1);
    @(posedge sys_clk_i) wake_src_i.ctimer <= 1'b0;
  endtask

  // mode register: software wait request, state readback, wake
  task t_mode();
    bus(1'b0, PMS_IDX_MODE, 32'h2, r);
    bus(1'b1, PMS_IDX_MODE, 0, r);
    chk("mode wait", r, {30'd0, PMS_WAIT});
    chk("mode halt", {31'd0, cpu_halt_o}, 32'h1);
    @(posedge sys_clk_i) wake_src_i.timer16 <= 1'b1;
    seen12(1, 1'b0, ok); chk("t16 wake", {31'd0, ok}, 32'h1);
    @(posedge sys_clk_i) wake_src_i.timer16 <= 1'b0;
    bus(1'b1, PMS_IDX_MODE, 0, r);
    chk("mode run", r, {30'd0, PMS_RUN});
  endtask

  // resets and the open-drain pin
  task t_resets();
    @(posedge sys_clk_i) lv_reset_i <= 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk("lvr pin", {30'd0, reset_pin_oe_o, reset_pin_o}, 32'h2);
    chk("lvr ports", port_dir_force_in_o, 32'hffff_ffff);
    @(posedge sys_clk_i) lv_reset_i <= 1'b0;
    wdog_reset_i <= 1'b1;
    repeat (3) @(negedge sys_clk_i);
    chk("wd pin", {30'd0, reset_pin_oe_o, chip_reset_o}, 32'h1);
    @(posedge sys_clk_i) wdog_reset_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    bus(1'b0, PMS_IDX_OPTIONS, 32'h10, r);
    @(posedge sys_clk_i) ext_rst_n <= 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk("pin rst", {31'd0, chip_reset_o}, 32'h1);
    @(posedge sys_clk_i) ext_rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    bus(1'b1, PMS_IDX_OPTIONS, 0, r); chk("pin clr", r, 32'h0);
  endtask

  // main sequence: each scenario judges its own results
  initial
  begin
    t_reset();
    t_regs();
    t_clocks();
    t_lowvolt();
    t_irq();
    t_stop();
    t_wait();
    t_mode();
    t_resets();
    test_done();
  end
endmodule
